//--- hw/dpo_pkg.sv
// Constants shared by the digitizer pixel output port and its buffer.
//------------------------------------------------------------------------------
// Overview of operation
// - Works normally with reset pin tied high
// - Word clock: pixel rate, half in wide
// - Second clock output is word clock inverted
// - Primary and secondary byte bus per colour
// - Aligned line sync travels with pixel data
// - Aligned line sync strips composite content
// - Frame sync eight pixels after line trailing
// - Buffered horizontal sync forwards source unchanged
// - Composite: vertical sync held during disruption
//------------------------------------------------------------------------------
package dpo_pkg;
    // Pixel and buffer geometry
    localparam int PIX_W = 8;
    localparam int FIFO_DEPTH = 8;
    localparam int WORD_W = 2 + 3 * PIX_W;
    // Buffer word fields
    localparam int FW_HS = 25;
    localparam int FW_FS = 24;
    localparam int FW_R_LSB = 16;
    localparam int FW_G_LSB = 8;
    localparam int FW_B_LSB = 0;
    // Input synchroniser bus fields
    localparam int IN_W = 32;
    localparam int SB_PCLK = 31;
    localparam int SB_RSTN = 30;
    localparam int SB_HSYNC = 29;
    localparam int SB_SOG = 28;
    localparam int SB_VSYNC = 27;
    localparam int SB_SEL = 26;
    localparam int SB_COMP = 25;
    localparam int SB_WIDE = 24;
    // Line measurement
    localparam int LINE_CNT_W = 12;
    localparam logic [LINE_CNT_W-1:0] LINE_CNT_MAX = 12'hFFF;
    localparam logic [LINE_CNT_W-1:0] LINE_CNT_ZERO = 12'h000;
    localparam logic [LINE_CNT_W-1:0] LINE_CNT_ONE = 12'h001;
    // Frame sync delay after line sync trailing edge, in pixels
    localparam logic [3:0] FS_DELAY_PIX = 4'h8;
    // Reset pin minimum low time
    localparam int CORE_CLK_MHZ = 125;
    localparam int RST_LOW_MIN_US = 1;
    localparam int RST_LOW_MIN_CYC = RST_LOW_MIN_US * CORE_CLK_MHZ;
    localparam logic [7:0] RST_CNT_LAST = 8'(RST_LOW_MIN_CYC - 1);
    // Reset values
    localparam logic [PIX_W-1:0] PIX_RST = 8'h00;
    localparam logic [WORD_W-1:0] WORD_RST = 26'h0000000;
    localparam logic [IN_W-1:0] IN_RST = 32'h40000000;
endpackage

//--- hw/dpo_fifo.sv
// Small synchronous FIFO with valid/ready on both sides.
`timescale 1ns/1ps
module dpo_fifo #(
    parameter int WIDTH = 26,
    parameter int DEPTH = 8
) (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic [WIDTH-1:0] in_data_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    output logic [WIDTH-1:0] out_data_o,
    output logic out_valid_o,
    input wire logic out_ready_i
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wr_ptr_ff;
    logic [AW:0] rd_ptr_ff;
    logic push;
    logic pop;

    // Full when pointers differ only in the wrap bit
    assign in_ready_o = !((wr_ptr_ff[AW] != rd_ptr_ff[AW]) &&
                          (wr_ptr_ff[AW-1:0] == rd_ptr_ff[AW-1:0]));
    assign out_valid_o = (wr_ptr_ff != rd_ptr_ff);
    assign out_data_o = mem[rd_ptr_ff[AW-1:0]];
    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;

    // Storage array, no reset needed
    always_ff @(posedge core_clk_i) begin
        if (push) begin
            mem[wr_ptr_ff[AW-1:0]] <= in_data_i;
        end
    end

    // Pointers
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
        end else begin
            if (push) begin
                wr_ptr_ff <= wr_ptr_ff + 1'b1;
            end
            if (pop) begin
                rd_ptr_ff <= rd_ptr_ff + 1'b1;
            end
        end
    end
endmodule // dpo_fifo

//--- hw/dpo_pixel_port.sv
// Pixel output port: sync processing, pixel buffering and output formatting.
`timescale 1ns/1ps
module dpo_pixel_port
    import dpo_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic sys_rst_i,
    input wire logic reset_pin_n_i,
    input wire logic pixel_clk_i,
    input wire logic [PIX_W-1:0] red_i,
    input wire logic [PIX_W-1:0] green_i,
    input wire logic [PIX_W-1:0] blue_i,
    input wire logic hsync_in_i,
    input wire logic sync_on_green_input_i,
    input wire logic vsync_in_i,
    input wire logic sync_src_sog_i,
    input wire logic composite_mode_i,
    input wire logic wide_mode_i,
    output logic [PIX_W-1:0] red_pri_o,
    output logic [PIX_W-1:0] red_sec_o,
    output logic [PIX_W-1:0] grn_pri_o,
    output logic [PIX_W-1:0] grn_sec_o,
    output logic [PIX_W-1:0] blu_pri_o,
    output logic [PIX_W-1:0] blu_sec_o,
    output logic output_word_clock_o,
    output logic output_word_clock_n_o,
    output logic aligned_line_sync_o,
    output logic synthetic_frame_sync_o,
    output logic buffered_horizontal_sync_o,
    output logic buffered_vertical_sync_o
);
    //--------------------------------------------------------------------------
    // Declarations
    //--------------------------------------------------------------------------
    logic [IN_W-1:0] sync1_ff;
    logic [IN_W-1:0] sync2_ff;
    logic pclk_d_ff;
    logic pix_rise;
    logic pix_fall;
    logic sel_s;
    logic vsync_s;
    logic comp_s;
    logic wide_s;
    logic pin_n_s;
    logic [7:0] rst_cnt_ff;
    logic pin_rst_ff;
    logic rst_int;
    logic prev_sel_ff;
    logic lead;
    logic trail;
    logic accept;
    logic reject;
    logic broad;
    logic [LINE_CNT_W-1:0] line_cnt_ff;
    logic [LINE_CNT_W-1:0] period_ff;
    logic [LINE_CNT_W-1:0] thr;
    logic [LINE_CNT_W-1:0] width_cnt_ff;
    logic [LINE_CNT_W-1:0] nom_w_ff;
    logic hs_al_ff;
    logic nxt_hs_al;
    logic line_bad_ff;
    logic disrupt_ff;
    logic vs_src;
    logic vs_src_d_ff;
    logic arm_ff;
    logic [3:0] fs_cnt_ff;
    logic fs_ff;
    logic nxt_fs;
    logic [WORD_W-1:0] cap_word_ff;
    logic cap_vld_ff;
    logic fifo_in_ready;
    logic [WORD_W-1:0] fifo_word;
    logic fifo_valid;
    logic pop_en;
    logic phase_ff;
    logic [WORD_W-1:0] stage_ff;

    //--------------------------------------------------------------------------
    // Input synchronisers and pixel clock edges
    //--------------------------------------------------------------------------
    // Two flops on every pin; pixel data and clock share latency
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            sync1_ff <= IN_RST;
            sync2_ff <= IN_RST;
        end else begin
            sync1_ff <= {pixel_clk_i, reset_pin_n_i, hsync_in_i, sync_on_green_input_i,
                         vsync_in_i, sync_src_sog_i, composite_mode_i, wide_mode_i,
                         red_i, green_i, blue_i};
            sync2_ff <= sync1_ff;
        end
    end

    // Edge detect on the sampled pixel clock
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            pclk_d_ff <= 1'b0;
        end else begin
            pclk_d_ff <= sync2_ff[SB_PCLK];
        end
    end

    assign pix_rise = sync2_ff[SB_PCLK] && !pclk_d_ff;
    assign pix_fall = !sync2_ff[SB_PCLK] && pclk_d_ff;
    assign sel_s = sync2_ff[SB_SEL] ? sync2_ff[SB_SOG] : sync2_ff[SB_HSYNC];
    assign vsync_s = sync2_ff[SB_VSYNC];
    assign comp_s = sync2_ff[SB_COMP];
    assign wide_s = sync2_ff[SB_WIDE];
    assign pin_n_s = sync2_ff[SB_RSTN];

    //--------------------------------------------------------------------------
    // Reset pin filter
    //--------------------------------------------------------------------------
    // Minimum low time
    // Tied-high pin never resets
    // Short glitches on the pin are ignored; only a low held for 125 core cycles resets the port
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i || pin_n_s) begin
            rst_cnt_ff <= 8'h00;
            pin_rst_ff <= 1'b0;
        end else if (rst_cnt_ff == RST_CNT_LAST) begin
            pin_rst_ff <= 1'b1;
        end else begin
            rst_cnt_ff <= rst_cnt_ff + 8'h01;
        end
    end

    assign rst_int = sys_rst_i || pin_rst_ff;

    //--------------------------------------------------------------------------
    // Line sync separation, at pixel rate
    //--------------------------------------------------------------------------
    assign lead = pix_rise && sel_s && !prev_sel_ff;
    assign trail = pix_rise && !sel_s && prev_sel_ff;
    assign thr = period_ff - (period_ff >> 2);
    // Reject half-line edges
    // Serration and equalising edges arrive well before a full line
    assign accept = lead && (!comp_s || (period_ff == LINE_CNT_ZERO) || (line_cnt_ff >= thr));
    assign reject = lead && !accept;
    assign broad = comp_s && (nom_w_ff != LINE_CNT_ZERO) &&
                   ({1'b0, width_cnt_ff} > {nom_w_ff, 1'b0});

    // Aligned line sync next value
    always_comb begin
        nxt_hs_al = hs_al_ff;
        if (accept) begin
            nxt_hs_al = 1'b1;
        end else if (trail) begin
            nxt_hs_al = 1'b0;
        end else if (pix_rise && comp_s && (nom_w_ff != LINE_CNT_ZERO) &&
                     (width_cnt_ff >= nom_w_ff)) begin
            nxt_hs_al = 1'b0;
        end
    end

    // Line period and pulse width measurement
    always_ff @(posedge core_clk_i) begin
        if (rst_int) begin
            prev_sel_ff <= 1'b0;
            line_cnt_ff <= LINE_CNT_ZERO;
            period_ff <= LINE_CNT_ZERO;
            width_cnt_ff <= LINE_CNT_ZERO;
            nom_w_ff <= LINE_CNT_ZERO;
            hs_al_ff <= 1'b0;
        end else if (pix_rise) begin
            prev_sel_ff <= sel_s;
            hs_al_ff <= nxt_hs_al;
            if (accept) begin
                line_cnt_ff <= LINE_CNT_ONE;
                if (!line_bad_ff) begin
                    period_ff <= line_cnt_ff;
                end
            end else if (line_cnt_ff != LINE_CNT_MAX) begin
                line_cnt_ff <= line_cnt_ff + LINE_CNT_ONE;
            end
            if (lead) begin
                width_cnt_ff <= LINE_CNT_ONE;
            end else if (sel_s && (width_cnt_ff != LINE_CNT_MAX)) begin
                width_cnt_ff <= width_cnt_ff + LINE_CNT_ONE;
            end
            // Learn nominal width only from clean lines
            if (trail && !line_bad_ff && !broad) begin
                nom_w_ff <= width_cnt_ff;
            end
        end
    end

    // Disruption tracking
    // A bad event sets at once and wins; a clean line clears at its end
    always_ff @(posedge core_clk_i) begin
        if (rst_int) begin
            line_bad_ff <= 1'b0;
            disrupt_ff <= 1'b0;
        end else if (pix_rise && (reject || (trail && broad))) begin
            line_bad_ff <= 1'b1;
            disrupt_ff <= 1'b1;
        end else if (accept) begin
            disrupt_ff <= line_bad_ff;
            line_bad_ff <= 1'b0;
        end
    end

    //--------------------------------------------------------------------------
    // Synthetic frame sync
    //--------------------------------------------------------------------------
    assign vs_src = comp_s ? disrupt_ff : vsync_s;

    always_comb begin
        nxt_fs = fs_ff;
        if (pix_rise && (fs_cnt_ff == FS_DELAY_PIX)) begin
            nxt_fs = arm_ff;
        end
    end

    // Armed by a frame start, fires once per frame for one line
    always_ff @(posedge core_clk_i) begin
        if (rst_int) begin
            vs_src_d_ff <= 1'b0;
            arm_ff <= 1'b0;
            fs_cnt_ff <= 4'h0;
            fs_ff <= 1'b0;
        end else begin
            vs_src_d_ff <= vs_src;
            fs_ff <= nxt_fs;
            if (vs_src && !vs_src_d_ff) begin
                arm_ff <= 1'b1;
            end else if (pix_rise && (fs_cnt_ff == FS_DELAY_PIX)) begin
                arm_ff <= 1'b0;
            end
            if (pix_rise) begin
                if (hs_al_ff && !nxt_hs_al) begin
                    fs_cnt_ff <= 4'h1;
                end else if (fs_cnt_ff == FS_DELAY_PIX) begin
                    fs_cnt_ff <= 4'h0;
                end else if (fs_cnt_ff != 4'h0) begin
                    fs_cnt_ff <= fs_cnt_ff + 4'h1;
                end
            end
        end
    end

    //--------------------------------------------------------------------------
    // Capture into the buffer
    //--------------------------------------------------------------------------
    // Sync flags ride with pixel
    // Held until the buffer accepts or the next pixel overwrites it; a full buffer does not stall capture
    always_ff @(posedge core_clk_i) begin
        if (rst_int) begin
            cap_word_ff <= WORD_RST;
            cap_vld_ff <= 1'b0;
        end else if (pix_rise) begin
            cap_word_ff <= {nxt_hs_al, nxt_fs, sync2_ff[3*PIX_W-1:0]};
            cap_vld_ff <= 1'b1;
        end else if (fifo_in_ready) begin
            cap_vld_ff <= 1'b0;
        end
    end

    dpo_fifo #(
        .WIDTH(WORD_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .core_clk_i(core_clk_i),
        .rst_i(rst_int),
        .in_data_i(cap_word_ff),
        .in_valid_i(cap_vld_ff),
        .in_ready_o(fifo_in_ready),
        .out_data_o(fifo_word),
        .out_valid_o(fifo_valid),
        .out_ready_i(pix_fall)
    );

    // Drain only on pixel falling edges so data is stable at word clock rise
    assign pop_en = pix_fall && fifo_valid;

    //--------------------------------------------------------------------------
    // Output formatter
    //--------------------------------------------------------------------------
    // Six byte buses
    always_ff @(posedge core_clk_i) begin
        if (rst_int) begin
            phase_ff <= 1'b0;
            stage_ff <= WORD_RST;
            red_pri_o <= PIX_RST;
            grn_pri_o <= PIX_RST;
            blu_pri_o <= PIX_RST;
            red_sec_o <= PIX_RST;
            grn_sec_o <= PIX_RST;
            blu_sec_o <= PIX_RST;
            aligned_line_sync_o <= 1'b0;
            synthetic_frame_sync_o <= 1'b0;
        end else if (pop_en && !wide_s) begin
            phase_ff <= 1'b0;
            red_pri_o <= fifo_word[FW_R_LSB +: PIX_W];
            grn_pri_o <= fifo_word[FW_G_LSB +: PIX_W];
            blu_pri_o <= fifo_word[FW_B_LSB +: PIX_W];
            red_sec_o <= PIX_RST;
            grn_sec_o <= PIX_RST;
            blu_sec_o <= PIX_RST;
            aligned_line_sync_o <= fifo_word[FW_HS];
            synthetic_frame_sync_o <= fifo_word[FW_FS];
        end else if (pop_en && !phase_ff) begin
            phase_ff <= 1'b1;
            stage_ff <= fifo_word;
        end else if (pop_en) begin
            phase_ff <= 1'b0;
            red_pri_o <= stage_ff[FW_R_LSB +: PIX_W];
            grn_pri_o <= stage_ff[FW_G_LSB +: PIX_W];
            blu_pri_o <= stage_ff[FW_B_LSB +: PIX_W];
            red_sec_o <= fifo_word[FW_R_LSB +: PIX_W];
            grn_sec_o <= fifo_word[FW_G_LSB +: PIX_W];
            blu_sec_o <= fifo_word[FW_B_LSB +: PIX_W];
            aligned_line_sync_o <= stage_ff[FW_HS] || fifo_word[FW_HS];
            synthetic_frame_sync_o <= stage_ff[FW_FS] || fifo_word[FW_FS];
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_int) begin
            output_word_clock_o <= 1'b0;
            output_word_clock_n_o <= 1'b1;
        end else if (!wide_s) begin
            output_word_clock_o <= sync2_ff[SB_PCLK];
            output_word_clock_n_o <= !sync2_ff[SB_PCLK];
        end else if (pop_en) begin
            output_word_clock_o <= !phase_ff;
            output_word_clock_n_o <= phase_ff;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_int) begin
            buffered_horizontal_sync_o <= 1'b0;
            buffered_vertical_sync_o <= 1'b0;
        end else begin
            buffered_horizontal_sync_o <= sel_s;
            buffered_vertical_sync_o <= vs_src;
        end
    end

    //--------------------------------------------------------------------------
    // Assertions
    //--------------------------------------------------------------------------
    logic [2:0] fall_cnt_ff;
    logic wc_seen_ff;

    // Pixel falls since last word clock fall, for the wide-rate check
    always_ff @(posedge core_clk_i) begin
        if (rst_int) begin
            fall_cnt_ff <= 3'h0;
            wc_seen_ff <= 1'b0;
        end else if (output_word_clock_o && !(output_word_clock_o && pop_en && phase_ff)) begin
            fall_cnt_ff <= (pix_fall && fall_cnt_ff != 3'h7) ? fall_cnt_ff + 3'h1 : fall_cnt_ff;
        end else if (pop_en && phase_ff) begin
            fall_cnt_ff <= 3'h1;
            wc_seen_ff <= 1'b1;
        end else if (pix_fall && fall_cnt_ff != 3'h7) begin
            fall_cnt_ff <= fall_cnt_ff + 3'h1;
        end
    end

    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (rst_int);

    property p_wc_comp;
        output_word_clock_n_o == !output_word_clock_o;
    endproperty
    a_wc_comp: assert property (p_wc_comp) else $error("word clock complement wrong");

    property p_wc_narrow;
        (!wide_s && $past(!wide_s)) ##0 $fell(output_word_clock_o) |-> $past(pix_fall);
    endproperty
    a_wc_narrow: assert property (p_wc_narrow) else $error("narrow word clock off pixel");

    property p_wc_wide;
        (wide_s && $past(wide_s) && wc_seen_ff && pop_en && phase_ff) |-> fall_cnt_ff == 3'h2
            ##1 $fell(output_word_clock_o);
    endproperty
    a_wc_wide: assert property (p_wc_wide) else $error("wide word clock rate wrong");

    property p_pair;
        (wide_s && pop_en && phase_ff) |=> (red_sec_o == $past(fifo_word[FW_R_LSB +: PIX_W]))
            && (red_pri_o == $past(stage_ff[FW_R_LSB +: PIX_W]));
    endproperty
    a_pair: assert property (p_pair) else $error("wide pixel pairing wrong");

    property p_hs_accept;
        $past(comp_s) && $rose(hs_al_ff) |->
            $past(period_ff == LINE_CNT_ZERO || line_cnt_ff >= thr);
    endproperty
    a_hs_accept: assert property (p_hs_accept) else $error("half-line edge passed");

    property p_fs_delay;
        $rose(fs_ff) |-> $past(fs_cnt_ff) == FS_DELAY_PIX && $past(pix_rise);
    endproperty
    a_fs_delay: assert property (p_fs_delay) else $error("frame sync delay wrong");

    property p_bhs;
        $past(!rst_int) |-> buffered_horizontal_sync_o == $past(sel_s);
    endproperty
    a_bhs: assert property (p_bhs) else $error("buffered hsync altered");

    property p_bvs;
        (comp_s && disrupt_ff) |=> buffered_vertical_sync_o;
    endproperty
    a_bvs: assert property (p_bvs) else $error("vsync dropped during disruption");

    property p_hs_data;
        $changed(aligned_line_sync_o) |-> $past(pop_en);
    endproperty
    a_hs_data: assert property (p_hs_data) else $error("line sync moved without data");

    // Pin filter checks must not be masked by the reset they produce
    property p_pin_high;
        disable iff (sys_rst_i)
        pin_n_s |=> !pin_rst_ff;
    endproperty
    a_pin_high: assert property (p_pin_high) else $error("reset without pin low");

    property p_pin_low;
        disable iff (sys_rst_i)
        $rose(pin_rst_ff) |-> $past(rst_cnt_ff) == RST_CNT_LAST;
    endproperty
    a_pin_low: assert property (p_pin_low) else $error("pin reset too early");

    c_wide_pair: cover property (wide_s && pop_en && phase_ff);
    c_frame_sync: cover property ($rose(fs_ff));
    c_disrupt: cover property ($rose(disrupt_ff));
    c_fifo_full: cover property (cap_vld_ff && !fifo_in_ready);
endmodule // dpo_pixel_port

//--- dv/dpo_rx_model.sv
// Receiver model that latches pixel words off the forwarded word clock.
`timescale 1ns/1ps
module dpo_rx_model
    import dpo_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic word_clk_i,
    input wire logic [3*PIX_W-1:0] pri_i,
    input wire logic [3*PIX_W-1:0] sec_i,
    input wire logic line_i,
    input wire logic frame_i,
    input wire logic vsync_i,
    output logic frame_start_o,
    output logic got_o,
    output logic [6*PIX_W+1:0] word_o,
    output int period_o
);
    logic wc_ff;
    logic vs_ff;
    int cnt_ff;
    // Latch after the fall, so the buses have had a full cycle to settle
    always_ff @(posedge core_clk_i) begin
        wc_ff <= word_clk_i;
        got_o <= wc_ff & ~word_clk_i;
        if (wc_ff & ~word_clk_i) begin
            word_o <= {line_i, frame_i, pri_i, sec_i};
        end
    end
    // Word clock period in core cycles, rise to rise
    always_ff @(posedge core_clk_i) begin
        cnt_ff <= (~wc_ff & word_clk_i) ? 1 : cnt_ff + 1;
        if (~wc_ff & word_clk_i) begin
            period_o <= cnt_ff;
        end
    end
    always_ff @(posedge core_clk_i) begin
        vs_ff <= vsync_i;
        frame_start_o <= vsync_i & ~vs_ff;
    end
endmodule // dpo_rx_model

//--- dv/dpo_pixel_port_tb.sv
// Self-checking bench for the pixel output port.
`timescale 1ns/1ps
module dpo_pixel_port_tb
    import dpo_pkg::*;
;
    logic clk, rst, rst_n, pclk, hs_in, sync_on_green_input, vs_in, sel, comp, wide;
    logic [PIX_W-1:0] r, g, b, rp, rs, gp, gs, bp, bs;
    logic wc, wcn, ls, fs, bhs, bvs, got, chk, lmask, half, pl, pf, fdone, fst;
    int fcnt;
    logic [6*PIX_W+1:0] w, e, eh;
    logic [6*PIX_W+1:0] q[$];
    logic [2:0] h;
    logic [31:0] x = 32'h0001566A;
    int per, bad_count, compares, widx, fall_idx, rise_idx;

    initial begin
        clk = 0;
        forever #4 clk = ~clk;
    end

    dpo_pixel_port uut (
        .core_clk_i(clk), .sys_rst_i(rst), .reset_pin_n_i(rst_n), .pixel_clk_i(pclk),
        .red_i(r), .green_i(g), .blue_i(b), .hsync_in_i(hs_in), .sync_on_green_input_i(sync_on_green_input),
        .vsync_in_i(vs_in), .sync_src_sog_i(sel), .composite_mode_i(comp), .wide_mode_i(wide),
        .red_pri_o(rp), .red_sec_o(rs), .grn_pri_o(gp), .grn_sec_o(gs), .blu_pri_o(bp),
        .blu_sec_o(bs), .output_word_clock_o(wc), .output_word_clock_n_o(wcn),
        .aligned_line_sync_o(ls), .synthetic_frame_sync_o(fs),
        .buffered_horizontal_sync_o(bhs), .buffered_vertical_sync_o(bvs)
    );
    dpo_rx_model rx (
        .core_clk_i(clk), .word_clk_i(wc), .pri_i({rp, gp, bp}), .sec_i({rs, gs, bs}),
        .line_i(ls), .frame_i(fs), .vsync_i(bvs), .frame_start_o(fst), .got_o(got),
        .word_o(w), .period_o(per)
    );

    //--------------------------------------------------------------------------
    // Helpers
    //--------------------------------------------------------------------------
    function automatic logic [31:0] rnd();
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        x = x ^ (x << 5);
        return x;
    endfunction
    task automatic check(input logic [63:0] seen, input logic [63:0] want);
        compares++;
        if (seen !== want) begin
            bad_count++;
            $display("[FAIL] t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask
    task automatic end_of_test();
        $display("compares=%0d bad_count=%0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // Three cycles of reset, then four more cycles flush the synchronisers
    task automatic do_reset(input logic s, input logic c, input logic wd);
        @(negedge clk);
        chk = 0; rst = 1; pclk = 0; sel = s; comp = c; wide = wd;
        q.delete(); half = 0; widx = 0; rise_idx = 0; fall_idx = 0; pl = 0; pf = 0;
        fcnt = 0;
        repeat (3) @(negedge clk);
        check({wc, wcn, rp, rs, gp, gs, bp, bs, ls, fs, bhs, bvs}, {2'b01, 52'h0});
        rst = 0;
        repeat (4) @(negedge clk);
        chk = 1;
    endtask
    // One pixel: 160 ns period, data changes while the pixel clock is low
    task automatic pix(input logic hs, input logic vs);
        logic [31:0] d;
        d = rnd();
        @(negedge clk);
        pclk = 0; {r, g, b} = d[23:0]; vs_in = vs;
        hs_in = sel ? d[24] : hs;
        sync_on_green_input = sel ? hs : d[25];
        repeat (10) @(negedge clk);
        pclk = 1;
        if (!wide) q.push_back({hs, 1'b0, d[23:0], 24'h000000});
        else if (!half) eh = {hs, 1'b0, d[23:0], 24'h000000};
        else q.push_back({eh[49] | hs, 1'b0, eh[47:24], d[23:0]});
        half = wide & ~half;
        repeat (9) @(negedge clk);
    endtask
    // A line with a two-pixel sync pulse, optionally a serration at mid-line
    task automatic line(input int n, input logic mid);
        for (int i = 0; i < n; i++) pix(i < 2 || (mid && (i == 8 || i == 9)), 1'b0);
    endtask

    // Selected sync source seen at each edge, for the pass-through compare
    always @(posedge clk) h <= {h[1:0], sel ? sync_on_green_input : hs_in};
    // Output monitor; frame flag is judged by its position only
    always @(negedge clk) begin
        if (chk) check(wcn, !wc);
        if (chk && fst) fcnt++;
        if (chk) check(bhs, h[2]);
        if (chk && got) begin
            e = q.size() ? q.pop_front() : '1;
            check({w[49] & ~lmask, w[47:0]}, {e[49] & ~lmask, e[47:0]});
            widx++;
            if (pl && !w[49]) fall_idx = widx;
            if (!pl && w[49] && comp && rise_idx > 0) check(widx - rise_idx < 12, 0);
            if (!pl && w[49]) rise_idx = widx;
            if (!fdone && !pf && w[48]) check(widx - fall_idx, 8);
            if (!pf && w[48]) fdone = 1;
            pl = w[49];
            pf = w[48];
        end
    end
    // Watchdog: the sequence needs about 6600 cycles
    initial begin
        #200000;
        bad_count++;
        end_of_test();
    end

    //--------------------------------------------------------------------------
    // Main sequence
    //--------------------------------------------------------------------------
    initial begin
        {rst_n, pclk, hs_in, sync_on_green_input, vs_in, r, g, b, lmask, bad_count, compares} = '0;
        rst = 1;
        rst_n = 1;
        fdone = 1;
        do_reset(0, 0, 0);
        fdone = 0;
        repeat (2) pix(0, 1);
        repeat (4) line(12 + rnd() % 8, 0);
        check(per, 20);
        check(fdone, 1);
        check(fcnt, 1);
        do_reset(1, 0, 1);
        repeat (4) line(16, 0);
        check(per, 40);
        do_reset(0, 1, 0);
        lmask = 1;
        repeat (6) line(16, 0);
        repeat (3) line(16, 1);
        check(bvs, 1);
        check(fcnt, 1);
        repeat (3) line(16, 0);
        check(bvs, 0);
        chk = 0;
        hs_in = 1;
        repeat (8) @(negedge clk);
        rst_n = 0;
        repeat (50) @(negedge clk);
        check(bhs, 1);
        rst_n = 1;
        repeat (8) @(negedge clk);
        check(bhs, 1);
        rst_n = 0;
        repeat (140) @(negedge clk);
        check({bhs, wcn}, 2'h1);
        rst_n = 1;
        repeat (8) @(negedge clk);
        end_of_test();
    end
endmodule // dpo_pixel_port_tb
